// >>> hdl/pecu_counter.sv
// One wrapping 32-bit counter with clear, load and wrap pulse
`timescale 1ns/1ps
`default_nettype none
module pecu_counter (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic inc,
    input wire logic clr,
    input wire logic ld,
    input wire logic [31:0] ld_val,
    output logic [31:0] cnt,
    output logic wrap
);

    // Count state
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;

    // Next count: clear, then load, then increment
    always_comb
    begin
        cnt_d = cnt_q;
        if (clr)
        begin
            cnt_d = pecu_pkg::CNT_RST;
        end
        else if (ld)
        begin
            cnt_d = ld_val;
        end
        else if (inc)
        begin
            cnt_d = cnt_q + 32'h0000_0001;
        end
    end

    // Wrap from all ones to zero marks overflow
    assign wrap = inc & ~clr & ~ld & (&cnt_q);

    // Count register
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_q <= pecu_pkg::CNT_RST;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

    assign cnt = cnt_q;

endmodule
`default_nettype wire

// >>> hdl/pecu_pkg.sv
// Package of constants and carrier types for the performance event counter unit
//
// Summary of operation
// - Interrupt raised when flag and enable both set
// - Interrupt holds until software writes one to flag
// - Counters keep counting in debug mode
// - Counters undefined after leaving active power mode
// - Counters wrap and keep counting after overflow
// - Each event counter has its own event select
// - Codes 0x0, 0x3, 0x4 count per occurrence
// - Code 0x1 counts each fetch-starved cycle
// - Code 0x2 counts each data-dependency stall cycle
// - Code 0x5 counts branches, 0x7 instructions
// - Code 0x6 counts immediate-branch mispredictions
// - Code 0x8 counts each buffer-full stall cycle
// - Code 0x9 counts each buffer-full stall episode once
// - Code 0xA counts data accesses, not maintenance
// - Code 0xB counts data misses, not maintenance
// - Code 0xC counts each half-line written back
// - Code 0xD counts PC writes without mode change
// - One global enable runs all three counters
// - Flags read one on overflow, write one clears
// - Per-counter interrupt enables gate reporting
// - Reset clears global enable and interrupt enables
package pecu_pkg;

    // Register byte offsets on the APB
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_CYC = 12'h004;
    localparam logic [11:0] OFS_CNT_A = 12'h008;
    localparam logic [11:0] OFS_CNT_B = 12'h00C;

    // Counter geometry and indices
    localparam int CNT_W = 32;
    localparam int NCNT = 3;
    localparam int IDX_A = 0;
    localparam int IDX_B = 1;
    localparam int IDX_CYC = 2;

    // Control register field positions
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_PRST_BIT = 1;
    localparam int CTL_CRST_BIT = 2;
    localparam int CTL_DIV_BIT = 3;
    localparam int CTL_INTEN_LSB = 4;
    localparam int CTL_FLAG_LSB = 8;
    localparam int CTL_SELA_LSB = 12;
    localparam int CTL_SELB_LSB = 20;
    localparam int SEL_W = 8;

    // Values after reset
    localparam logic CTL_EN_RST = 1'b0;
    localparam logic CTL_DIV_RST = 1'b0;
    localparam logic [2:0] CTL_INTEN_RST = 3'h0;
    localparam logic [2:0] CTL_FLAG_RST = 3'h0;
    localparam logic [7:0] CTL_SEL_RST = 8'h00;
    localparam logic [31:0] CNT_RST = 32'h0000_0000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    localparam logic IRQ_RST = 1'b0;
    localparam logic EDGE_RST = 1'b0;

    // Cycle counter slow rate: one tick every 64 clocks
    localparam int DIV_CYCLES = 64;
    localparam int DIV_W = 6;
    localparam logic [5:0] DIV_LAST = 6'(DIV_CYCLES - 1);
    localparam logic [5:0] DIV_RST = 6'h00;

    // Event select codes
    localparam logic [7:0] EV_IC_MISS = 8'h00;
    localparam logic [7:0] EV_IF_STALL = 8'h01;
    localparam logic [7:0] EV_DEP_STALL = 8'h02;
    localparam logic [7:0] EV_ITLB_MISS = 8'h03;
    localparam logic [7:0] EV_DTLB_MISS = 8'h04;
    localparam logic [7:0] EV_BRANCH = 8'h05;
    localparam logic [7:0] EV_BR_MISP = 8'h06;
    localparam logic [7:0] EV_INSTR = 8'h07;
    localparam logic [7:0] EV_BUF_CYC = 8'h08;
    localparam logic [7:0] EV_BUF_EPI = 8'h09;
    localparam logic [7:0] EV_DC_ACC = 8'h0A;
    localparam logic [7:0] EV_DC_MISS = 8'h0B;
    localparam logic [7:0] EV_DC_WB = 8'h0C;
    localparam logic [7:0] EV_SW_PC = 8'h0D;
    localparam logic [7:0] EV_NUM = 8'h0E;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pecu_apb_req_t;

    // Event strobes from pipeline, caches and TLBs
    typedef struct packed {
        logic ic_miss_fetch;
        logic if_stall;
        logic dep_stall;
        logic itlb_miss;
        logic dtlb_miss;
        logic branch_exec;
        logic imm_br_misp;
        logic instr_exec;
        logic dbuf_full;
        logic dc_access;
        logic dc_miss;
        logic dc_maint;
        logic wb_half_line;
        logic pc_write;
        logic mode_change;
    } pecu_core_ev_t;

endpackage

// >>> hdl/pecu_top.sv
// Performance event counter unit with APB register slave
`timescale 1ns/1ps
`default_nettype none
module pecu_top (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire pecu_pkg::pecu_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pecu_pkg::pecu_core_ev_t core_ev,
    output logic ovf_irq
);

    // Control register state
    logic en_q;
    logic en_d;
    logic div_q;
    logic div_d;
    logic [2:0] inten_q;
    logic [2:0] inten_d;
    logic [2:0] flag_q;
    logic [2:0] flag_d;
    logic [7:0] sel_a_q;
    logic [7:0] sel_a_d;
    logic [7:0] sel_b_q;
    logic [7:0] sel_b_d;

    // Prescaler for the slow cycle count rate
    logic [5:0] pre_q;
    logic [5:0] pre_d;
    logic pre_tick;

    // Episode edge detector for buffer-full stalls
    logic buf_prev_q;
    logic buf_prev_d;

    // Read data and interrupt registers
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic irq_q;
    logic irq_d;

    // Bus decode
    logic acc;
    logic wr;
    logic rd_setup;
    logic hit_ctl;
    logic hit_cyc;
    logic hit_a;
    logic hit_b;
    logic hit_any;
    logic ctl_wr;
    logic prst;
    logic crst;

    // Per-counter controls and results
    logic [2:0] inc_v;
    logic [2:0] clr_v;
    logic [2:0] ld_v;
    logic [2:0] wrap_v;
    logic [31:0] cnt_v [3];
    logic [7:0] sel_v [2];
    logic [15:0] ev_vec;
    logic [31:0] ctl_rd;

    // Address decode against fixed offsets
    assign hit_ctl = apb_req.paddr == pecu_pkg::OFS_CTRL;
    assign hit_cyc = apb_req.paddr == pecu_pkg::OFS_CYC;
    assign hit_a = apb_req.paddr == pecu_pkg::OFS_CNT_A;
    assign hit_b = apb_req.paddr == pecu_pkg::OFS_CNT_B;
    assign hit_any = hit_ctl | hit_cyc | hit_a | hit_b;

    // Zero-wait slave: the access phase always completes
    assign acc = apb_req.psel & apb_req.penable;
    assign pready = 1'b1;
    assign pslverr = acc & ~hit_any;
    assign wr = acc & apb_req.pwrite & hit_any;
    assign rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
    assign ctl_wr = wr & hit_ctl;

    // Counter reset strobes, write-only
    assign prst = ctl_wr & apb_req.pwdata[pecu_pkg::CTL_PRST_BIT];
    assign crst = ctl_wr & apb_req.pwdata[pecu_pkg::CTL_CRST_BIT];

    // Event vector indexed by select code
    always_comb
    begin
        ev_vec = 16'h0000;
        ev_vec[pecu_pkg::EV_IC_MISS[3:0]] = core_ev.ic_miss_fetch;
        ev_vec[pecu_pkg::EV_IF_STALL[3:0]] = core_ev.if_stall;
        ev_vec[pecu_pkg::EV_DEP_STALL[3:0]] = core_ev.dep_stall;
        ev_vec[pecu_pkg::EV_ITLB_MISS[3:0]] = core_ev.itlb_miss;
        ev_vec[pecu_pkg::EV_DTLB_MISS[3:0]] = core_ev.dtlb_miss;
        ev_vec[pecu_pkg::EV_BRANCH[3:0]] = core_ev.branch_exec;
        // Core flags only immediate-branch mispredictions here
        ev_vec[pecu_pkg::EV_BR_MISP[3:0]] = core_ev.imm_br_misp;
        ev_vec[pecu_pkg::EV_INSTR[3:0]] = core_ev.instr_exec;
        ev_vec[pecu_pkg::EV_BUF_CYC[3:0]] = core_ev.dbuf_full;
        // Rising edge only: one count per stall episode
        ev_vec[pecu_pkg::EV_BUF_EPI[3:0]] = core_ev.dbuf_full & ~buf_prev_q;
        // Maintenance operations masked out
        ev_vec[pecu_pkg::EV_DC_ACC[3:0]] = core_ev.dc_access & ~core_ev.dc_maint;
        ev_vec[pecu_pkg::EV_DC_MISS[3:0]] = core_ev.dc_miss & ~core_ev.dc_maint;
        ev_vec[pecu_pkg::EV_DC_WB[3:0]] = core_ev.wb_half_line;
        // Exceptions that change mode do not count
        ev_vec[pecu_pkg::EV_SW_PC[3:0]] = core_ev.pc_write & ~core_ev.mode_change;
    end

    // Select fields in counter order
    assign sel_v[pecu_pkg::IDX_A] = sel_a_q;
    assign sel_v[pecu_pkg::IDX_B] = sel_b_q;

    // Event counters: each follows its own select
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_ev
            // Reserved codes never count; no debug-mode gating
            assign inc_v[gi] = en_q & (sel_v[gi] < pecu_pkg::EV_NUM)
                & ev_vec[sel_v[gi][3:0]];
            assign clr_v[gi] = prst;
        end
    endgenerate

    // Cycle counter runs every clock or every 64th
    assign pre_tick = pre_q == pecu_pkg::DIV_LAST;
    assign inc_v[pecu_pkg::IDX_CYC] = en_q & (~div_q | pre_tick);
    assign clr_v[pecu_pkg::IDX_CYC] = crst;

    // Direct loads of the counter registers
    assign ld_v[pecu_pkg::IDX_A] = wr & hit_a;
    assign ld_v[pecu_pkg::IDX_B] = wr & hit_b;
    assign ld_v[pecu_pkg::IDX_CYC] = wr & hit_cyc;

    // The three counters; there is no power-mode input, so after a power change
    // the counts are whatever the counters hold and software must not trust them
    generate
        for (gi = 0; gi < pecu_pkg::NCNT; gi++)
        begin : g_cnt
            pecu_counter u_cnt (
                .sys_clk(sys_clk),
                .nrst(nrst),
                .inc(inc_v[gi]),
                .clr(clr_v[gi]),
                .ld(ld_v[gi]),
                .ld_val(apb_req.pwdata),
                .cnt(cnt_v[gi]),
                .wrap(wrap_v[gi])
            );
        end
    endgenerate

    // Control register image as read back
    always_comb
    begin
        ctl_rd = 32'h0000_0000;
        ctl_rd[pecu_pkg::CTL_EN_BIT] = en_q;
        ctl_rd[pecu_pkg::CTL_DIV_BIT] = div_q;
        ctl_rd[pecu_pkg::CTL_INTEN_LSB +: 3] = inten_q;
        ctl_rd[pecu_pkg::CTL_FLAG_LSB +: 3] = flag_q;
        ctl_rd[pecu_pkg::CTL_SELA_LSB +: pecu_pkg::SEL_W] = sel_a_q;
        ctl_rd[pecu_pkg::CTL_SELB_LSB +: pecu_pkg::SEL_W] = sel_b_q;
    end

    // Next control state from writes and counter events
    always_comb
    begin
        en_d = en_q;
        div_d = div_q;
        inten_d = inten_q;
        sel_a_d = sel_a_q;
        sel_b_d = sel_b_q;
        flag_d = flag_q;
        // Software write of the control register
        if (ctl_wr)
        begin
            en_d = apb_req.pwdata[pecu_pkg::CTL_EN_BIT];
            div_d = apb_req.pwdata[pecu_pkg::CTL_DIV_BIT];
            inten_d = apb_req.pwdata[pecu_pkg::CTL_INTEN_LSB +: 3];
            sel_a_d = apb_req.pwdata[pecu_pkg::CTL_SELA_LSB +: pecu_pkg::SEL_W];
            sel_b_d = apb_req.pwdata[pecu_pkg::CTL_SELB_LSB +: pecu_pkg::SEL_W];
            // Write one clears, write zero keeps
            flag_d = flag_q & ~apb_req.pwdata[pecu_pkg::CTL_FLAG_LSB +: 3];
        end
        // A wrap in the clearing cycle still sets the flag
        flag_d = flag_d | wrap_v;
    end

    // Next prescaler and edge state
    always_comb
    begin
        pre_d = pre_q;
        if (crst)
        begin
            pre_d = pecu_pkg::DIV_RST;
        end
        else if (en_q)
        begin
            pre_d = pre_tick ? pecu_pkg::DIV_RST : pre_q + 6'h01;
        end
        buf_prev_d = core_ev.dbuf_full;
    end

    // Interrupt follows enabled flags, held until cleared
    always_comb
    begin
        irq_d = |(flag_d & inten_d);
    end

    // Read data captured in the setup cycle
    always_comb
    begin
        rdata_d = rdata_q;
        if (rd_setup)
        begin
            if (hit_ctl)
            begin
                rdata_d = ctl_rd;
            end
            else if (hit_cyc)
            begin
                rdata_d = cnt_v[pecu_pkg::IDX_CYC];
            end
            else if (hit_a)
            begin
                rdata_d = cnt_v[pecu_pkg::IDX_A];
            end
            else if (hit_b)
            begin
                rdata_d = cnt_v[pecu_pkg::IDX_B];
            end
            else
            begin
                // Unmapped address reads zero
                rdata_d = 32'h0000_0000;
            end
        end
    end

    // Register the control state
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            en_q <= pecu_pkg::CTL_EN_RST;
            inten_q <= pecu_pkg::CTL_INTEN_RST;
            div_q <= pecu_pkg::CTL_DIV_RST;
            flag_q <= pecu_pkg::CTL_FLAG_RST;
            sel_a_q <= pecu_pkg::CTL_SEL_RST;
            sel_b_q <= pecu_pkg::CTL_SEL_RST;
        end
        else
        begin
            en_q <= en_d;
            inten_q <= inten_d;
            div_q <= div_d;
            flag_q <= flag_d;
            sel_a_q <= sel_a_d;
            sel_b_q <= sel_b_d;
        end
    end

    // Register the prescaler and the stall edge detector
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pre_q <= pecu_pkg::DIV_RST;
            // Idle level of the stall strobe, so no false episode after reset
            buf_prev_q <= pecu_pkg::EDGE_RST;
        end
        else
        begin
            pre_q <= pre_d;
            buf_prev_q <= buf_prev_d;
        end
    end

    // Register the read data so the bus sees a flop output
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata_q <= pecu_pkg::RDATA_RST;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // Register the interrupt so the pin never glitches
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_q <= pecu_pkg::IRQ_RST;
        end
        else
        begin
            irq_q <= irq_d;
        end
    end

    // Outputs from registers
    assign prdata = rdata_q;
    assign ovf_irq = irq_q;

endmodule
`default_nettype wire

// >>> tb/pecu_core_model.sv
// Core-side model turning a bench command into event strobes
`timescale 1ns/1ps
`default_nettype none
module pecu_core_model (
    input wire logic fire,
    input wire logic [7:0] code,
    input wire logic maint,
    output pecu_pkg::pecu_core_ev_t core_ev
);
    // Raise the commanded strobe and, with maint set, both qualifiers; reserved codes raise only those qualifiers
    always_comb
    begin
        core_ev = '0;
        if (fire)
        begin
            case (code)
                8'h00: core_ev.ic_miss_fetch = 1'b1;
                8'h01: core_ev.if_stall = 1'b1;
                8'h02: core_ev.dep_stall = 1'b1;
                8'h03: core_ev.itlb_miss = 1'b1;
                8'h04: core_ev.dtlb_miss = 1'b1;
                8'h05: core_ev.branch_exec = 1'b1;
                8'h06: core_ev.imm_br_misp = 1'b1;
                8'h07: core_ev.instr_exec = 1'b1;
                8'h08, 8'h09: core_ev.dbuf_full = 1'b1;
                8'h0A: core_ev.dc_access = 1'b1;
                8'h0B: core_ev.dc_miss = 1'b1;
                8'h0C: core_ev.wb_half_line = 1'b1;
                8'h0D: core_ev.pc_write = 1'b1;
                default: core_ev = '0;
            endcase
            // Maintenance and mode change qualify the same strobe
            core_ev.dc_maint = maint;
            core_ev.mode_change = maint;
        end
    end
endmodule
`default_nettype wire

// >>> tb/pecu_monitor.sv
// Checker for the port behaviour of the event counter unit
`timescale 1ns/1ps
`default_nettype none
module pecu_monitor (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire pecu_pkg::pecu_apb_req_t apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire pecu_pkg::pecu_core_ev_t core_ev,
    input wire logic ovf_irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    // Access phase and decode helpers
    wire logic acc = apb_req.psel && apb_req.penable;
    wire logic rd_acc = acc && !apb_req.pwrite;
    wire logic ctl_wr = acc && apb_req.pwrite && apb_req.paddr == pecu_pkg::OFS_CTRL;
    wire logic unmap = apb_req.paddr > pecu_pkg::OFS_CNT_B;
    logic cause_q; // An event or a control write happened last cycle
    // Remember whether anything could have raised the interrupt
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            cause_q <= 1'b0;
        else
            cause_q <= (core_ev != '0) || ctl_wr;
    end
    property p_ready;
        pready;
    endproperty
    a_ready: assert property (p_ready) else $error("ready low");
    property p_err;
        rd_acc && unmap |-> pslverr && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("unmapped read not refused");
    property p_ok;
        acc && !unmap |-> !pslverr;
    endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
    property p_resv;
        rd_acc && apb_req.paddr == pecu_pkg::OFS_CTRL
            |-> prdata[31:28] == 4'h0 && !prdata[11] && !prdata[7] && prdata[2:1] == 2'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved control bits nonzero");
    property p_rise;
        $rose(ovf_irq) |-> cause_q;
    endproperty
    a_rise: assert property (p_rise) else $error("interrupt rose without cause");
    property p_hold;
        ovf_irq && !ctl_wr |=> ovf_irq;
    endproperty
    a_hold: assert property (p_hold) else $error("interrupt dropped on its own");
    property p_noen;
        ctl_wr && apb_req.pwdata[6:4] == 3'h0 |=> !ovf_irq;
    endproperty
    a_noen: assert property (p_noen) else $error("interrupt with enables off");
    property p_clr;
        ctl_wr && apb_req.pwdata[10:8] == 3'h7 && core_ev == '0 |=> !ovf_irq;
    endproperty
    a_clr: assert property (p_clr) else $error("flag clear kept interrupt");
    c_irq: cover property ($rose(ovf_irq));
    c_err: cover property (rd_acc && unmap);
    c_clr: cover property (ctl_wr && apb_req.pwdata[8]);
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the performance event counter unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk = 1'b0; // 125 MHz clock
    logic nrst = 1'b0; // Active-low reset
    pecu_pkg::pecu_apb_req_t apb_req = '0; // Bus request
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ovf_irq;
    pecu_pkg::pecu_core_ev_t core_ev; // Strobes from the core model
    logic fire = 1'b0; // Event command
    logic [7:0] code = 8'h00;
    logic maint = 1'b0;
    int miscompares = 0;
    int samples_checked = 0;
    logic [31:0] rd; // Last read value
    logic [31:0] rd2;
    logic [31:0] ctl; // Control word under test
    int k;
    always #4 sys_clk = ~sys_clk;
    pecu_top pecu_top_i (.sys_clk(sys_clk), .nrst(nrst), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_ev(core_ev), .ovf_irq(ovf_irq));
    pecu_core_model pecu_core_model_i (.fire(fire), .code(code), .maint(maint), .core_ev(core_ev));
    // Final report and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Compare one value against its expectation
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One APB transfer: setup, access until ready, then release
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (n == 16 && pready !== 1'b1)
        begin
            miscompares++;
            print_verdict();
        end
        rd = prdata;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    task automatic rdr(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    // Hold one event strobe for n cycles
    task automatic pulse(input logic [7:0] c, input int n, input logic m);
        @(posedge sys_clk);
        code <= c;
        maint <= m;
        fire <= 1'b1;
        repeat (n) @(posedge sys_clk);
        fire <= 1'b0;
    endtask
    // Expected count of one burst of n cycles
    function automatic logic [31:0] want(input logic [7:0] c, input int n, input logic m);
        if (m && (c == 8'h0A || c == 8'h0B || c == 8'h0D))
            return 32'h0;
        return (c == 8'h09) ? 32'h1 : 32'(n);
    endfunction
    // Enabled control word with interrupt enables and both selects
    function automatic logic [31:0] ctlw(input logic [2:0] ie, input logic [7:0] sa,
        input logic [7:0] sb);
        return 32'h1 | (32'(ie) << pecu_pkg::CTL_INTEN_LSB) |
            (32'(sa) << pecu_pkg::CTL_SELA_LSB) | (32'(sb) << pecu_pkg::CTL_SELB_LSB);
    endfunction
    // Main sequence
    initial
    begin
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        rdr(pecu_pkg::OFS_CTRL);
        check("ctrl_rst", rd, 32'h0);
        rdr(pecu_pkg::OFS_CNT_A);
        check("cnt_a_rst", rd, 32'h0);
        rdr(12'h010);
        check("unmapped", rd, 32'h0);
        // Global enable runs and stops the cycle counter and stops event counter A
        apb(1'b1, pecu_pkg::OFS_CTRL, 32'h5);
        rdr(pecu_pkg::OFS_CYC);
        rd2 = rd;
        rdr(pecu_pkg::OFS_CYC);
        check("cyc_run", rd - rd2, 32'h3);
        apb(1'b1, pecu_pkg::OFS_CTRL, 32'h7002);
        rdr(pecu_pkg::OFS_CYC);
        rd2 = rd;
        pulse(8'h07, 4, 1'b0);
        rdr(pecu_pkg::OFS_CYC);
        check("cyc_stop", rd - rd2, 32'h0);
        rdr(pecu_pkg::OFS_CNT_A);
        check("cnt_a_stop", rd, 32'h0);
        // Divider: bit 2 clears the prescaler, then one step per 64 enabled clocks
        apb(1'b1, pecu_pkg::OFS_CTRL, 32'hD);
        repeat (3 * pecu_pkg::DIV_CYCLES - 2) @(posedge sys_clk);
        rdr(pecu_pkg::OFS_CYC);
        check("cyc_div_before", rd, 32'h2);
        rdr(pecu_pkg::OFS_CYC);
        check("cyc_div_after", rd, 32'h3);
        // Every code 0x0 to 0xD on both counters, plain and qualified bursts
        for (k = 0; k < 14; k++)
        begin
            ctl = ctlw(3'h0, 8'(k), 8'(13 - k));
            apb(1'b1, pecu_pkg::OFS_CTRL, ctl | 32'h2);
            pulse(8'(k), 3, 1'b0);
            pulse(8'(k), 2, 1'b1);
            pulse(8'(13 - k), 2, 1'b0);
            pulse(8'(13 - k), 2, 1'b1);
            rdr(pecu_pkg::OFS_CNT_A);
            rd2 = want(8'(k), 3, 1'b0) + want(8'(k), 2, 1'b1);
            check("cnt_a_ev", rd, rd2);
            rdr(pecu_pkg::OFS_CNT_B);
            rd2 = want(8'(13 - k), 2, 1'b0) + want(8'(13 - k), 2, 1'b1);
            check("cnt_b_ev", rd, rd2);
        end
        // Buffer-full pairing: duration on A, episodes on B from one stall
        apb(1'b1, pecu_pkg::OFS_CTRL, ctlw(3'h0, 8'h08, 8'h09) | 32'h2);
        pulse(8'h08, 5, 1'b0);
        rdr(pecu_pkg::OFS_CNT_A);
        check("pair_cycles", rd, want(8'h08, 5, 1'b0));
        rdr(pecu_pkg::OFS_CNT_B);
        check("pair_episodes", rd, want(8'h09, 5, 1'b0));
        // Wrap, flag, interrupt gating and write-one clear
        ctl = ctlw(3'h1, 8'h07, 8'h07);
        apb(1'b1, pecu_pkg::OFS_CTRL, ctl);
        apb(1'b1, pecu_pkg::OFS_CNT_A, 32'hFFFF_FFFE);
        apb(1'b1, pecu_pkg::OFS_CNT_B, 32'hFFFF_FFFF);
        pulse(8'h07, 1, 1'b0);
        @(negedge sys_clk);
        check("irq_masked", ovf_irq, 32'h0);
        pulse(8'h07, 1, 1'b0);
        @(negedge sys_clk);
        // Only the pin is checked; unmasking beyond it is the system's job
        check("irq_set", ovf_irq, 32'h1);
        rdr(pecu_pkg::OFS_CTRL);
        check("flags", rd[10:8], 32'h3);
        rdr(pecu_pkg::OFS_CNT_A);
        check("wrap_a", rd, 32'h0);
        rdr(pecu_pkg::OFS_CNT_B);
        check("wrap_b", rd, 32'h1);
        apb(1'b1, pecu_pkg::OFS_CTRL, ctl | 32'h200);
        @(negedge sys_clk);
        check("irq_hold", ovf_irq, 32'h1);
        apb(1'b1, pecu_pkg::OFS_CTRL, ctl | 32'h700);
        @(negedge sys_clk);
        check("irq_clr", ovf_irq, 32'h0);
        rdr(pecu_pkg::OFS_CTRL);
        check("flags_clr", rd[10:8], 32'h0);
        print_verdict();
    end
endmodule
bind pecu_top pecu_monitor pecu_monitor_i (.sys_clk(sys_clk), .nrst(nrst), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_ev(core_ev), .ovf_irq(ovf_irq));
`default_nettype wire
